// ### logic/sms_spi.sv
/*
 * mode 0 serial master and serial slave behind special function registers.
 * assumes a single-cycle register port on sys_clk_i and external pins that
 * are asynchronous to it; pin direction logic sits outside.
 */
`timescale 1ns/1ns
module sms_spi
    import sms_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_WORDS
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire sms_sfr_req_t sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    output logic master_sck_o,
    output logic master_serial_out_o,
    input wire logic master_serial_in_i,
    output logic master_ready_irq_o,
    input wire logic slave_select_in_n_i,
    input wire logic slave_serial_in_i,
    input wire logic slave_serial_clock_i,
    output logic slave_serial_out_o,
    output logic slave_serial_out_oe_o,
    output logic slave_irq_request_flag_o
);
    // half serial period in core cycles for a divider code
    function automatic logic [5:0] half_cycles(input logic [3:0] code);
        case (code)
            4'h0, 4'h1: half_cycles = 6'd1;
            4'h2: half_cycles = 6'd2;
            4'h3: half_cycles = 6'd4;
            4'h4: half_cycles = 6'd8;
            4'h5: half_cycles = 6'd16;
            default: half_cycles = 6'd32;
        endcase
    endfunction

    logic wr_mdat, wr_mctl, wr_scfg, wr_sdat, rd_sdat, rd_sflag;
    assign wr_mdat = sfr_req_i.wr && (sfr_req_i.addr == ADDR_MASTER_SHIFT_DATA);
    assign wr_mctl = sfr_req_i.wr && (sfr_req_i.addr == ADDR_MASTER_CONTROL);
    assign wr_scfg = sfr_req_i.wr && (sfr_req_i.addr == ADDR_SLAVE_CONFIG);
    assign wr_sdat = sfr_req_i.wr && (sfr_req_i.addr == ADDR_SLAVE_SHIFT_DATA);
    assign rd_sdat = sfr_req_i.rd && (sfr_req_i.addr == ADDR_SLAVE_SHIFT_DATA);
    assign rd_sflag = sfr_req_i.rd && (sfr_req_i.addr == ADDR_SLAVE_EVENT_FLAGS);

    // two-stage synchronisers for all pins, then a previous-value stage
    // order: 3 master in, 2 slave select, 1 slave data in, 0 slave clock
    logic [3:0] pin_meta_ff, pin_sync_ff, pin_prev_ff;
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            // idle pin levels: select high, data and clocks low, so no false edge
            pin_meta_ff <= 4'h4;
            pin_sync_ff <= 4'h4;
            pin_prev_ff <= 4'h4;
        end
        else
        begin
            pin_meta_ff <= {master_serial_in_i, slave_select_in_n_i,
                            slave_serial_in_i, slave_serial_clock_i};
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    // master
    sms_mstate_t mstate_ff, nxt_mstate;
    logic [7:0] mctl_ff, nxt_mctl, msh_ff, nxt_msh;
    logic [5:0] div_cnt_ff, nxt_div_cnt;
    logic [3:0] falls_ff, nxt_falls;
    logic [2:0] dly_ff, nxt_dly;
    logic [1:0] rise_dly_ff, nxt_rise_dly;
    logic [7:0] mrx_ff, nxt_mrx;
    logic sck_ff, nxt_sck, ready_ff, nxt_ready, half_tick;

    // one-cycle enable every half serial period
    assign half_tick = (div_cnt_ff == half_cycles(mctl_ff[MCTL_DIV_MSB:0]) - 6'd1);

    // transfer sequencer: wait half period, eight pulses, ready delay
    always_comb
    begin
        nxt_mstate = mstate_ff;
        nxt_mctl = wr_mctl ? {3'b000, sfr_req_i.wdata[4:0]} : mctl_ff;
        nxt_msh = msh_ff;
        nxt_div_cnt = half_tick ? 6'd0 : div_cnt_ff + 6'd1;
        nxt_falls = falls_ff;
        nxt_dly = dly_ff;
        nxt_sck = sck_ff;
        // a rise is taken two cycles late, which undoes the pin synchroniser delay
        nxt_rise_dly = {rise_dly_ff[0], 1'b0};
        nxt_mrx = rise_dly_ff[1] ? {mrx_ff[6:0], pin_sync_ff[3]} : mrx_ff;
        nxt_ready = ready_ff;
        case (mstate_ff)
            M_IDLE:
            begin
                if (wr_mdat && mctl_ff[MCTL_ENABLE_BIT])
                begin
                    nxt_msh = sfr_req_i.wdata;
                    nxt_ready = 1'b0;
                    nxt_div_cnt = 6'd0;
                    nxt_falls = 4'd0;
                    nxt_mstate = M_SHIFT;
                end
            end
            M_SHIFT:
            begin
                if (half_tick && !sck_ff)
                begin
                    nxt_sck = 1'b1;
                    nxt_rise_dly[0] = 1'b1;
                end
                else if (half_tick)
                begin
                    nxt_sck = 1'b0;
                    nxt_msh = {msh_ff[6:0], 1'b0};
                    nxt_falls = falls_ff + 4'd1;
                    if (falls_ff == 4'(BITS_PER_BYTE - 1))
                    begin
                        nxt_dly = 3'd0;
                        nxt_mstate = M_DONE;
                    end
                end
            end
            M_DONE:
            begin
                nxt_dly = dly_ff + 3'd1;
                if (dly_ff == 3'(TDREADY_CYC - 1))
                begin
                    nxt_ready = 1'b1;
                    nxt_msh = mrx_ff;
                    nxt_mstate = M_IDLE;
                end
            end
            default: nxt_mstate = M_IDLE;
        endcase
        // disabling aborts a transfer and parks the clock low
        if (!mctl_ff[MCTL_ENABLE_BIT])
        begin
            nxt_mstate = M_IDLE;
            nxt_sck = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mstate_ff <= M_IDLE;
            mctl_ff <= REG_RESET;
            msh_ff <= REG_RESET;
            div_cnt_ff <= 6'd0;
            falls_ff <= 4'd0;
            dly_ff <= 3'd0;
            sck_ff <= 1'b0;
            rise_dly_ff <= 2'b00;
            mrx_ff <= REG_RESET;
            ready_ff <= 1'b0;
        end
        else
        begin
            mstate_ff <= nxt_mstate;
            mctl_ff <= nxt_mctl;
            msh_ff <= nxt_msh;
            div_cnt_ff <= nxt_div_cnt;
            falls_ff <= nxt_falls;
            dly_ff <= nxt_dly;
            sck_ff <= nxt_sck;
            rise_dly_ff <= nxt_rise_dly;
            mrx_ff <= nxt_mrx;
            ready_ff <= nxt_ready;
        end
    end

    assign master_sck_o = sck_ff;
    assign master_serial_out_o = msh_ff[7];
    assign master_ready_irq_o = ready_ff;

    // slave
    logic [7:0] scfg_ff, nxt_scfg, tx_buf_ff, nxt_tx_buf, tx_sh_ff, nxt_tx_sh;
    logic [7:0] rx_sh_ff, nxt_rx_sh, rx_byte, fifo_head;
    logic [2:0] sflag_ff, nxt_sflag, bit_cnt_ff, nxt_bit_cnt, flag_set;
    logic reload_ff, nxt_reload, fifo_in_valid, fifo_in_ready, fifo_out_valid;
    logic s_en, sel, cs_rise, cs_fall, sck_rise, sck_fall;

    assign s_en = scfg_ff[SCFG_ENABLE_BIT];
    assign sel = s_en && !pin_sync_ff[2];
    assign cs_rise = s_en && !pin_prev_ff[2] && pin_sync_ff[2];
    assign cs_fall = s_en && pin_prev_ff[2] && !pin_sync_ff[2];
    assign sck_rise = sel && !pin_prev_ff[0] && pin_sync_ff[0];
    assign sck_fall = sel && pin_prev_ff[0] && !pin_sync_ff[0];
    assign rx_byte = {rx_sh_ff[6:0], pin_sync_ff[1]};
    // a full buffer stalls bit capture until software drains it
    assign fifo_in_valid = sck_rise && fifo_in_ready && (bit_cnt_ff == 3'd7);

    // event causes, gated per edge by the config
    always_comb
    begin
        flag_set = 3'b000;
        flag_set[SFLAG_RISE_BIT] = cs_rise && !scfg_ff[SCFG_NO_RISE_IRQ_BIT];
        flag_set[SFLAG_FALL_BIT] = cs_fall && !scfg_ff[SCFG_NO_FALL_IRQ_BIT];
        flag_set[SFLAG_BYTE_BIT] = fifo_in_valid;
    end

    // slave shifter, config, transmit buffer and flags
    always_comb
    begin
        nxt_scfg = wr_scfg ? (sfr_req_i.wdata & SCFG_RW_MASK) : scfg_ff;
        nxt_tx_buf = wr_sdat ? sfr_req_i.wdata : tx_buf_ff;
        nxt_tx_sh = tx_sh_ff;
        nxt_rx_sh = rx_sh_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_reload = reload_ff;
        // a set in the same cycle as the clearing read survives
        nxt_sflag = (rd_sflag ? 3'b000 : sflag_ff) | flag_set;
        if (!sel)
            nxt_bit_cnt = 3'd0;
        if (cs_fall)
        begin
            nxt_tx_sh = tx_buf_ff;
            nxt_reload = 1'b0;
        end
        else if (sck_rise && fifo_in_ready)
        begin
            nxt_rx_sh = rx_byte;
            nxt_bit_cnt = bit_cnt_ff + 3'd1;
            nxt_reload = (bit_cnt_ff == 3'd7);
        end
        else if (sck_fall)
        begin
            nxt_tx_sh = reload_ff ? tx_buf_ff : {tx_sh_ff[6:0], 1'b0};
            nxt_reload = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scfg_ff <= REG_RESET;
            tx_buf_ff <= REG_RESET;
            tx_sh_ff <= REG_RESET;
            rx_sh_ff <= REG_RESET;
            sflag_ff <= 3'b000;
            bit_cnt_ff <= 3'd0;
            reload_ff <= 1'b0;
        end
        else
        begin
            scfg_ff <= nxt_scfg;
            tx_buf_ff <= nxt_tx_buf;
            tx_sh_ff <= nxt_tx_sh;
            rx_sh_ff <= nxt_rx_sh;
            sflag_ff <= nxt_sflag;
            bit_cnt_ff <= nxt_bit_cnt;
            reload_ff <= nxt_reload;
        end
    end

    // received bytes queue up until software reads the slave data register
    sms_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(rx_byte),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(rd_sdat),
        .out_data_o(fifo_head)
    );

    assign slave_serial_out_o = tx_sh_ff[7];
    assign slave_serial_out_oe_o = sel;
    assign slave_irq_request_flag_o = (sflag_ff != 3'b000) && !scfg_ff[SCFG_NO_IRQ_BIT];

    // register read port
    logic [7:0] rdata_ff, nxt_rdata;
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (sfr_req_i.rd)
        begin
            case (sfr_req_i.addr)
                ADDR_MASTER_SHIFT_DATA: nxt_rdata = msh_ff;
                ADDR_MASTER_CONTROL: nxt_rdata = mctl_ff;
                ADDR_SLAVE_CONFIG: nxt_rdata = scfg_ff;
                ADDR_SLAVE_SHIFT_DATA: nxt_rdata = fifo_out_valid ? fifo_head : 8'h00;
                ADDR_SLAVE_EVENT_FLAGS: nxt_rdata = {5'b00000, sflag_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_ff <= REG_RESET;
        else
            rdata_ff <= nxt_rdata;
    end

    assign sfr_rdata_o = rdata_ff;
endmodule

// ### logic/sms_pkg.sv
/*
 * shared constants and types of the serial master and slave units.
 * assumes one 8-bit special function register port from the core.
 */
package sms_pkg;
    // register offsets
    localparam logic [7:0] ADDR_MASTER_SHIFT_DATA = 8'hB2;
    localparam logic [7:0] ADDR_MASTER_CONTROL = 8'hB3;
    localparam logic [7:0] ADDR_SLAVE_CONFIG = 8'hBC;
    localparam logic [7:0] ADDR_SLAVE_SHIFT_DATA = 8'hBD;
    localparam logic [7:0] ADDR_SLAVE_EVENT_FLAGS = 8'hBE;
    localparam logic [7:0] REG_RESET = 8'h00;
    // field positions
    localparam int MCTL_ENABLE_BIT = 4;
    localparam int MCTL_DIV_MSB = 3;
    localparam int SCFG_ENABLE_BIT = 0;
    localparam int SCFG_NO_RISE_IRQ_BIT = 5;
    localparam int SCFG_NO_FALL_IRQ_BIT = 4;
    localparam int SCFG_NO_IRQ_BIT = 3;
    localparam int SFLAG_RISE_BIT = 2;
    localparam int SFLAG_FALL_BIT = 1;
    localparam int SFLAG_BYTE_BIT = 0;
    localparam logic [7:0] SCFG_RW_MASK = 8'h39;
    // timing counts and receive buffer depth
    localparam int BITS_PER_BYTE = 8;
    localparam int TDREADY_CYC = 7;
    localparam int FIFO_WORDS = 8;
    // special function register access
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sms_sfr_req_t;
    // master transfer sequence
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_SHIFT = 2'b01,
        M_DONE = 2'b10
    } sms_mstate_t;
endpackage

// ### logic/sms_fifo.sv
/*
 * small flip-flop fifo with valid/ready on both sides.
 * assumes one clock and an active low asynchronous reset.
 */
`timescale 1ns/1ns
module sms_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
    logic [CW-1:0] count_ff, nxt_count;
    logic push, pop;

    // honest full and empty from the word count
    assign in_ready_o = (count_ff != CW'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign out_data_o = mem_ff[rd_ptr_ff];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // pointer and count update, wrapping at depth
    always_comb
    begin
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        if (push)
            nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
        if (pop)
            nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
        nxt_count = count_ff + CW'(push) - CW'(pop);
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
        end
    end

    // storage, no reset needed
    always_ff @(posedge sys_clk_i)
    begin
        if (push)
            mem_ff[wr_ptr_ff] <= in_data_i;
    end
endmodule

// ### testbench/sms_spi_asserts.sv
/* port checker for the serial master and slave unit.
   bound to every sms_spi instance; sees its ports only. */
`timescale 1ns/1ns
module sms_spi_asserts
    import sms_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire sms_sfr_req_t sfr_req_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic master_sck_o,
    input wire logic master_serial_out_o,
    input wire logic master_ready_irq_o,
    input wire logic slave_select_in_n_i,
    input wire logic slave_serial_out_oe_o,
    input wire logic slave_irq_request_flag_o
);
    logic men_ff, busy_ff, cfg3_ff, sck_ff, nxt_men, nxt_busy, nxt_cfg3;
    logic [3:0] div_ff, nxt_div, cnt_ff, nxt_cnt;
    logic wr_b2, acc_wr;
    // a data write counts only while the master is enabled and idle
    assign wr_b2 = sfr_req_i.wr && sfr_req_i.addr == ADDR_MASTER_SHIFT_DATA;
    assign acc_wr = wr_b2 && men_ff && !busy_ff;
    // shadow of control bits and count of clock pulses per transfer
    always_comb
    begin
        nxt_men = men_ff;
        nxt_div = div_ff;
        nxt_cfg3 = cfg3_ff;
        if (sfr_req_i.wr && sfr_req_i.addr == ADDR_MASTER_CONTROL)
        begin
            nxt_men = sfr_req_i.wdata[MCTL_ENABLE_BIT];
            nxt_div = sfr_req_i.wdata[3:0];
        end
        if (sfr_req_i.wr && sfr_req_i.addr == ADDR_SLAVE_CONFIG)
        begin
            nxt_cfg3 = sfr_req_i.wdata[SCFG_NO_IRQ_BIT];
        end
        nxt_busy = acc_wr || (busy_ff && men_ff && !master_ready_irq_o);
        nxt_cnt = acc_wr ? 4'h0 : cnt_ff + {3'h0, master_sck_o && !sck_ff};
    end
    // shadow registers
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            {men_ff, busy_ff, cfg3_ff, sck_ff, div_ff, cnt_ff} <= '0;
        end
        else
        begin
            {men_ff, busy_ff, cfg3_ff, sck_ff, div_ff, cnt_ff} <=
                {nxt_men, nxt_busy, nxt_cfg3, master_sck_o, nxt_div, nxt_cnt};
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    sck_start_a: assert property (
        acc_wr && div_ff < 4'h2 |=> !master_sck_o ##1 master_sck_o)
        else $error("first serial clock rise not one half period after write");
    out_msb_a: assert property (
        acc_wr |=> master_serial_out_o == $past(sfr_req_i.wdata[7]))
        else $error("first serial bit is not the top data bit");
    pulse_count_a: assert property ($rose(master_ready_irq_o) |-> cnt_ff == 4'h8)
        else $error("transfer did not give eight clock pulses");
    ready_delay_a: assert property ($rose(master_ready_irq_o) |->
        !$past(master_sck_o, 7) && $past(master_sck_o, 8))
        else $error("ready not seven cycles after last clock pulse");
    ready_clear_a: assert property (wr_b2 && men_ff && master_ready_irq_o |=>
        !master_ready_irq_o)
        else $error("data write did not clear ready");
    ctl_spare_a: assert property (sfr_req_i.rd && sfr_req_i.addr == ADDR_MASTER_CONTROL
        |=> sfr_rdata_o[7:5] == 3'h0)
        else $error("unused control bits read nonzero");
    cfg_spare_a: assert property (sfr_req_i.rd && sfr_req_i.addr == ADDR_SLAVE_CONFIG
        |=> (sfr_rdata_o & ~SCFG_RW_MASK) == 8'h00)
        else $error("unused config bits read nonzero");
    irq_mask_a: assert property (cfg3_ff |-> !slave_irq_request_flag_o)
        else $error("slave request raised while all slave interrupts off");
    oe_idle_a: assert property (slave_select_in_n_i [*4] |-> !slave_serial_out_oe_o)
        else $error("slave output driven while not selected");
endmodule
bind sms_spi sms_spi_asserts u_chk (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .sfr_req_i(sfr_req_i),
    .sfr_rdata_o(sfr_rdata_o),
    .master_sck_o(master_sck_o),
    .master_serial_out_o(master_serial_out_o),
    .master_ready_irq_o(master_ready_irq_o),
    .slave_select_in_n_i(slave_select_in_n_i),
    .slave_serial_out_oe_o(slave_serial_out_oe_o),
    .slave_irq_request_flag_o(slave_irq_request_flag_o)
);

// ### testbench/sms_partner.sv
/* far side model: a mode 0 device on the master pins and a mode 0 host
   on the slave pins. assumes the bench drives the device select. */
`timescale 1ns/1ns
module sms_partner (
    input wire logic sys_clk_i,
    input wire logic master_sck_i,
    input wire logic master_serial_out_i,
    output logic master_serial_in_o,
    input wire logic dev_sel_n_i,
    input wire logic [7:0] dev_reply_i,
    output logic [7:0] dev_rx_o,
    output logic slave_select_in_n_o,
    output logic slave_serial_in_o,
    output logic slave_serial_clock_o,
    input wire logic slave_serial_out_i,
    input wire logic slave_serial_out_oe_i
);
    logic [7:0] dev_tx;
    wire slave_line = slave_serial_out_oe_i ? slave_serial_out_i : 1'bz;
    // idle pins: host deselected, clock low
    initial
    begin
        {master_serial_in_o, dev_rx_o, dev_tx} = '0;
        {slave_select_in_n_o, slave_serial_in_o, slave_serial_clock_o} = 3'h4;
    end
    // device loads its reply on select, shifts on falling clock, samples on rising
    always @(negedge dev_sel_n_i)
    begin
        dev_tx = dev_reply_i;
        master_serial_in_o = dev_reply_i[7];
    end
    always @(negedge master_sck_i)
    begin
        if (!dev_sel_n_i)
        begin
            dev_tx = {dev_tx[6:0], 1'b0};
            master_serial_in_o = dev_tx[7];
        end
    end
    always @(posedge master_sck_i)
    begin
        if (!dev_sel_n_i)
            dev_rx_o = {dev_rx_o[6:0], master_serial_out_i};
    end
    // a released line shows the inverse of its last level
    always @(posedge dev_sel_n_i)
    begin
        master_serial_in_o = ~master_serial_in_o;
    end
    // host transfer with 13-cycle clock phases to keep minimum high and low times
    task automatic host_xfer(input logic [7:0] tx, output logic [7:0] rx);
        @(posedge sys_clk_i);
        slave_select_in_n_o <= 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            slave_serial_in_o <= tx[i];
            repeat (13) @(posedge sys_clk_i);
            slave_serial_clock_o <= 1'b1;
            rx[i] = slave_line;
            repeat (13) @(posedge sys_clk_i);
            slave_serial_clock_o <= 1'b0;
        end
        repeat (13) @(posedge sys_clk_i);
        slave_select_in_n_o <= 1'b1;
        slave_serial_in_o <= ~slave_serial_in_o;
        repeat (40) @(posedge sys_clk_i);
    endtask
endmodule

// ### testbench/tb_spi_master_and_slave.sv
/* self-checking bench: registers, master transfers at divider codes 0 to 7 and F,
   slave transfers with event flags, and the receive buffer. uses sms_partner. */
`timescale 1ns/1ns
module tb_spi_master_and_slave
    import sms_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic dev_sel_n = 1'b1;
    logic [7:0] dev_reply = 8'h00;
    sms_sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata, dev_rx;
    logic sck, mosi, miso, ready_irq, sel_n, s_in, s_clk, s_out, s_oe, s_irq;
    int bad_count = 0;
    int checks_done = 0;
    // 250 MHz core clock
    always #2 sys_clk = ~sys_clk;
    sms_spi dut (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .sfr_req_i(sfr_req),
        .sfr_rdata_o(sfr_rdata), .master_sck_o(sck), .master_serial_out_o(mosi),
        .master_serial_in_i(miso), .master_ready_irq_o(ready_irq),
        .slave_select_in_n_i(sel_n), .slave_serial_in_i(s_in), .slave_serial_clock_i(s_clk),
        .slave_serial_out_o(s_out), .slave_serial_out_oe_o(s_oe),
        .slave_irq_request_flag_o(s_irq)
    );
    sms_partner peer (
        .sys_clk_i(sys_clk), .master_sck_i(sck), .master_serial_out_i(mosi),
        .master_serial_in_o(miso), .dev_sel_n_i(dev_sel_n), .dev_reply_i(dev_reply),
        .dev_rx_o(dev_rx), .slave_select_in_n_o(sel_n), .slave_serial_in_o(s_in),
        .slave_serial_clock_o(s_clk), .slave_serial_out_i(s_out), .slave_serial_out_oe_i(s_oe)
    );
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // register port cycles: strobe for one cycle, read data after the taking edge
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        sfr_req <= '0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        sfr_req <= '0;
        #1 chk(sfr_rdata, exp);
    endtask
    // reset values, unused bits and an unmapped place
    task automatic t_regs;
        logic [7:0] regs [6] = '{8'hB2, 8'hB3, 8'hBC, 8'hBD, 8'hBE, 8'hB0};
        foreach (regs[k])
            rd_chk(regs[k], REG_RESET);
        sfr_wr(ADDR_MASTER_CONTROL, 8'hFF);
        rd_chk(ADDR_MASTER_CONTROL, 8'h1F);
        sfr_wr(ADDR_SLAVE_CONFIG, 8'hFF);
        rd_chk(ADDR_SLAVE_CONFIG, 8'h39);
    endtask
    // one master transfer per divider code 0 to 7 and F: first clock delay, data both ways, ready
    task automatic t_master;
        int n;
        int h;
        logic [3:0] code;
        for (int c = 0; c < 9; c++)
        begin
            code = (c == 8) ? 4'hF : c[3:0];
            h = (code < 2) ? 1 : ((code < 7) ? (1 << (code - 1)) : 32);
            sfr_wr(ADDR_MASTER_CONTROL, {4'h1, code});
            dev_reply = 8'h5A ^ {4'h0, code};
            dev_sel_n = 1'b0;
            sfr_wr(ADDR_MASTER_SHIFT_DATA, 8'hC3 ^ {code, 4'h0});
            n = 0;
            while (sck !== 1'b1 && n < 100)
            begin
                @(posedge sys_clk);
                #1 n++;
            end
            chk(n[7:0], h[7:0]);
            n = 0;
            while (ready_irq !== 1'b1 && n < 3000)
            begin
                @(posedge sys_clk);
                #1 n++;
            end
            chk({7'h0, ready_irq}, 8'h01);
            dev_sel_n = 1'b1;
            chk(dev_rx, 8'hC3 ^ {code, 4'h0});
            rd_chk(ADDR_MASTER_SHIFT_DATA, 8'h5A ^ {4'h0, code});
        end
        sfr_wr(ADDR_MASTER_CONTROL, 8'h00);
    endtask
    // one host transfer under a given slave configuration
    task automatic slave_one(input logic [7:0] cfg, input logic [7:0] tx, input logic [7:0] fl);
        logic [7:0] rx;
        sfr_wr(ADDR_SLAVE_CONFIG, cfg);
        sfr_wr(ADDR_SLAVE_SHIFT_DATA, 8'h3C);
        peer.host_xfer(tx, rx);
        chk(rx, 8'h3C);
        chk({7'h0, s_irq}, {7'h0, fl != 8'h00 && !cfg[3]});
        rd_chk(ADDR_SLAVE_EVENT_FLAGS, fl);
        chk({7'h0, s_irq}, 8'h00);
        rd_chk(ADDR_SLAVE_SHIFT_DATA, tx);
    endtask
    // fill the receive buffer past its depth, then drain it to empty
    task automatic t_fifo;
        logic [7:0] rx;
        sfr_wr(ADDR_SLAVE_CONFIG, 8'h01);
        for (int i = 0; i <= FIFO_WORDS; i++)
            peer.host_xfer(8'h10 + i[7:0], rx);
        for (int i = 0; i <= FIFO_WORDS; i++)
            rd_chk(ADDR_SLAVE_SHIFT_DATA, (i < FIFO_WORDS) ? 8'h10 + i[7:0] : 8'h00);
    endtask
    // verdict and end of run
    task automatic close_out;
        if (bad_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_regs();
        t_master();
        slave_one(8'h01, 8'h96, 8'h07);
        slave_one(8'h31, 8'h69, 8'h01);
        slave_one(8'h21, 8'h5A, 8'h03);
        slave_one(8'h11, 8'h0F, 8'h05);
        slave_one(8'h09, 8'hA5, 8'h07);
        t_fifo();
        close_out();
    end
    // watchdog
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        bad_count++;
        close_out();
    end
endmodule
